/* wdp_consts.svh */
// constants for the watchdog and power-down wake-up block
`ifndef WDP_CONSTS_SVH
`define WDP_CONSTS_SVH
`define WDP_ADDR_WDCTRL 8'h00
`define WDP_ADDR_RSTCAUSE 8'h04
`define WDP_ADDR_PWRCTRL 8'h08
`define WDP_ADDR_STATUS 8'h0c
`define WDP_ADDR_WAKE 8'h10
`define WDP_WDCTRL_RESET 8'h53
`define WDP_KEY_DISABLE 5'h15
`define WDP_KEY_ENABLE 5'h0a
`define WDP_CLK_HZ 125000000
`define WDP_LOW_SPEED_RC_OSC_HZ 32000
`define WDP_LOW_SPEED_RC_OSC_DIV (`WDP_CLK_HZ / `WDP_LOW_SPEED_RC_OSC_HZ)
`define WDP_KEY_RESET_DELAY_US 100
`define WDP_KEY_RESET_CYCLES ((`WDP_KEY_RESET_DELAY_US * (`WDP_CLK_HZ / 1000000)))
`define WDP_FULL_RESET_CYCLES 16
`endif

/* wdp_cpu_model.sv */
// cpu core model: turns bench requests into halt and clear pulses
`timescale 1ns/1ns
`default_nettype none
module wdp_cpu_model (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // reset, active low
  input wire logic stall_i, // core stalled
  input wire logic halt_req_i, // request a halt
  input wire logic clr_req_i, // request a clear
  output logic halt_o, // halt pulse
  output logic clear_o // clear pulse
);
  logic halt_req_ff;
  logic clr_req_ff;
  // a stalled core executes nothing, so no instruction leaves it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_req_ff <= 1'b0;
      clr_req_ff <= 1'b0;
      halt_o <= 1'b0;
      clear_o <= 1'b0;
    end
    else
    begin
      halt_req_ff <= halt_req_i;
      clr_req_ff <= clr_req_i;
      halt_o <= halt_req_i && !halt_req_ff && !stall_i;
      clear_o <= clr_req_i && !clr_req_ff && !stall_i;
    end
  end
endmodule
`default_nettype wire

/* wdp_pkg.sv */
// types for the watchdog and power-down wake-up block
package wdp_pkg;
  typedef enum logic [2:0] {WDP_RUN, WDP_SLEEP, WDP_IDLE_SUB, WDP_IDLE_BOTH, WDP_IDLE_FAST}
    wdp_mode_e;
endpackage

/* wdp_watchdog.sv */
// watchdog timer with halt-mode control, wake-up and axi4-lite registers
`timescale 1ns/1ns
`default_nettype none
`include "wdp_consts.svh"
// Overview of operation
// - halt with fast keep 0, slow keep 1 enters sub-only idle
// - halt with both keep bits 1 enters idle with both clocks
// - halt with fast keep 1, slow keep 0 enters fast-only idle
// - halt with both keep bits 0 enters sleep, system clock stopped
// - entering power-down sets powerdown flag, clears expired flag
// - halt clears watchdog counter, which counts on only if enabled
// - wake on masked port A falling edge, interrupt, or overflow
// - powerdown flag set by halt, cleared by power-up or clear instruction
// - overflow while halted sets expired flag, resets only pc and sp
// - port A wake resumes after the halt instruction
// - interrupt wake: disabled or stack full resumes after halt, else vectors
// - interrupts already pending before halt cannot wake
// - watchdog from 32 kHz rc, select gives 2^8..2^15 cycles
// - key 10101 disables, key 01010 enables watchdog
// - any other key gives full reset after delay, sets key-reset flag
// - power-on loads enable key and period select 011
// - key-reset flag set by key reset, cleared only by power-up or software zero
// - overflow while running gives full reset, sets expired flag
// - counter cleared by key reset, clear instruction, or halt
module wdp_watchdog
  import wdp_pkg::*;
(
  input wire logic CLK_SYS_I, // system clock 125 MHz
  input wire logic RESET_N_I, // async reset, active low
  input wire logic [7:0] AWADDR_I, // write address
  input wire logic AWVALID_I, // write address valid
  output logic AWREADY_O, // write address ready
  input wire logic [31:0] WDATA_I, // write data
  input wire logic [3:0] WSTRB_I, // write strobes
  input wire logic WVALID_I, // write data valid
  output logic WREADY_O, // write data ready
  output logic [1:0] BRESP_O, // write response
  output logic BVALID_O, // write response valid
  input wire logic BREADY_I, // write response ready
  input wire logic [7:0] ARADDR_I, // read address
  input wire logic ARVALID_I, // read address valid
  output logic ARREADY_O, // read address ready
  output logic [31:0] RDATA_O, // read data
  output logic [1:0] RRESP_O, // read response
  output logic RVALID_O, // read valid
  input wire logic RREADY_I, // read ready
  input wire logic HALT_I, // halt instruction executed, pulse
  input wire logic CLEAR_WDT_I, // clear-watchdog instruction, pulse
  input wire logic [7:0] PORTA_I, // port A pins
  input wire logic [7:0] IRQ_REQ_I, // interrupt request flags
  input wire logic [7:0] IRQ_EN_I, // interrupt enables
  input wire logic STACK_FULL_I, // cpu stack full
  output logic CPU_STALL_O, // program execution stopped
  output logic HS_CLK_EN_O, // high-speed clock running
  output logic SUB_CLK_EN_O, // sub clock running
  output logic SYS_CLK_EN_O, // system clock running
  output logic WAKE_RESUME_O, // pulse: resume after halt
  output logic WAKE_IRQ_O, // pulse: take interrupt response
  output logic PC_SP_RESET_O, // pulse: clear pc and sp only
  output logic FULL_RESET_O, // full device reset request
  output logic POWERDOWN_FLAG_O, // powerdown flag
  output logic WATCHDOG_EXPIRED_FLAG_O // watchdog-expired flag
);

  logic [7:0] wdctrl_ff;
  logic key_reset_flag_ff;
  logic fast_osc_halt_keep_ff;
  logic slow_osc_halt_keep_ff;
  logic [7:0] porta_wake_mask_ff;
  logic powerdown_flag_ff;
  logic watchdog_expired_flag_ff;
  wdp_mode_e mode_ff;
  logic [14:0] wdt_cnt_ff;
  logic [12:0] low_speed_rc_osc_div_ff;
  logic low_speed_rc_osc_tick;
  logic [7:0] porta_d_ff;
  logic [7:0] irq_mask_ff;
  logic [15:0] key_delay_ff;
  logic key_pending_ff;
  logic [4:0] full_rst_ff;
  logic wdt_enable;
  logic key_bad;
  logic overflow;
  logic [14:0] cnt_inc;
  logic halted;
  logic porta_wake;
  logic irq_wake;
  logic wake;
  logic aw_ok_ff;
  logic w_ok_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `WDP_ADDR_WDCTRL) || (a == `WDP_ADDR_RSTCAUSE) ||
      (a == `WDP_ADDR_PWRCTRL) || (a == `WDP_ADDR_STATUS) || (a == `WDP_ADDR_WAKE);
  endfunction

  // axi4-lite write: address and data taken in either order
  assign AWREADY_O = !aw_ok_ff && !BVALID_O;
  assign WREADY_O = !w_ok_ff && !BVALID_O;
  assign wr_go = aw_ok_ff && w_ok_ff && !BVALID_O;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'b00;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_ok_ff <= 1'b1;
        wdata_ff <= WDATA_I;
        wstrb_ff <= WSTRB_I;
      end
      if (wr_go)
      begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= addr_mapped(awaddr_ff) ? 2'b00 : 2'b10;
      end
      else if (BVALID_O && BREADY_I)
        BVALID_O <= 1'b0;
    end
  end

  // axi4-lite read: one-cycle answer after the address is taken
  assign ARREADY_O = !RVALID_O;

  always_comb
  begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    if (ARADDR_I == `WDP_ADDR_WDCTRL)
      rd_val = {24'h0, wdctrl_ff};
    else if (ARADDR_I == `WDP_ADDR_RSTCAUSE)
      rd_val = {31'h0, key_reset_flag_ff};
    else if (ARADDR_I == `WDP_ADDR_PWRCTRL)
      rd_val = {30'h0, fast_osc_halt_keep_ff, slow_osc_halt_keep_ff};
    else if (ARADDR_I == `WDP_ADDR_STATUS)
      rd_val = {26'h0, watchdog_expired_flag_ff, powerdown_flag_ff, 1'b0, mode_ff};
    else if (ARADDR_I == `WDP_ADDR_WAKE)
      rd_val = {24'h0, porta_wake_mask_ff};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0;
      RRESP_O <= 2'b00;
    end
    else if (ARVALID_I && ARREADY_O)
    begin
      RVALID_O <= 1'b1;
      RDATA_O <= rd_val;
      RRESP_O <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (RVALID_O && RREADY_I)
      RVALID_O <= 1'b0;
  end

  // register writes; wdctrl restored to power-on value by a key reset
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      wdctrl_ff <= `WDP_WDCTRL_RESET;
      fast_osc_halt_keep_ff <= 1'b0;
      slow_osc_halt_keep_ff <= 1'b0;
      porta_wake_mask_ff <= 8'h00;
    end
    else if (FULL_RESET_O)
    begin
      wdctrl_ff <= `WDP_WDCTRL_RESET;
      fast_osc_halt_keep_ff <= 1'b0;
      slow_osc_halt_keep_ff <= 1'b0;
      porta_wake_mask_ff <= 8'h00;
    end
    else if (wr_go && wstrb_ff[0])
    begin
      if (awaddr_ff == `WDP_ADDR_WDCTRL)
        wdctrl_ff <= wdata_ff[7:0];
      else if (awaddr_ff == `WDP_ADDR_PWRCTRL)
      begin
        fast_osc_halt_keep_ff <= wdata_ff[1];
        slow_osc_halt_keep_ff <= wdata_ff[0];
      end
      else if (awaddr_ff == `WDP_ADDR_WAKE)
        porta_wake_mask_ff <= wdata_ff[7:0];
    end
  end

  assign wdt_enable = (wdctrl_ff[7:3] == `WDP_KEY_ENABLE);
  assign key_bad = (wdctrl_ff[7:3] != `WDP_KEY_ENABLE) &&
    (wdctrl_ff[7:3] != `WDP_KEY_DISABLE);

  // key-reset flag: survives the full reset it causes; set beats clear
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      key_reset_flag_ff <= 1'b0;
    else if (key_pending_ff && key_delay_ff == 16'h0)
      key_reset_flag_ff <= 1'b1;
    else if (wr_go && wstrb_ff[0] && awaddr_ff == `WDP_ADDR_RSTCAUSE && !wdata_ff[0])
      key_reset_flag_ff <= 1'b0;
  end

  // key-reset delay then a fixed-length full reset pulse
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      key_pending_ff <= 1'b0;
      key_delay_ff <= 16'h0;
    end
    else if (key_pending_ff)
    begin
      if (key_delay_ff == 16'h0)
        key_pending_ff <= 1'b0;
      else
        key_delay_ff <= key_delay_ff - 16'h1;
    end
    else if (key_bad && !FULL_RESET_O)
    begin
      key_pending_ff <= 1'b1;
      key_delay_ff <= 16'(`WDP_KEY_RESET_CYCLES - 1);
    end
  end

  assign FULL_RESET_O = (full_rst_ff != 5'h0);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      full_rst_ff <= 5'h0;
    else if ((key_pending_ff && key_delay_ff == 16'h0) || (overflow && !halted))
      full_rst_ff <= 5'(`WDP_FULL_RESET_CYCLES);
    else if (FULL_RESET_O)
      full_rst_ff <= full_rst_ff - 5'h1;
  end

  // low-speed rc tick: one-cycle enable from the system clock
  assign low_speed_rc_osc_tick = (low_speed_rc_osc_div_ff == 13'(`WDP_LOW_SPEED_RC_OSC_DIV - 1));

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      low_speed_rc_osc_div_ff <= 13'h0;
    else if (low_speed_rc_osc_tick)
      low_speed_rc_osc_div_ff <= 13'h0;
    else
      low_speed_rc_osc_div_ff <= low_speed_rc_osc_div_ff + 13'h1;
  end

  // overflow when the selected bit falls on the next increment
  assign cnt_inc = wdt_cnt_ff + 15'h1;
  assign overflow = wdt_enable && low_speed_rc_osc_tick && !FULL_RESET_O &&
    wdt_cnt_ff[7 + wdctrl_ff[2:0]] && !cnt_inc[7 + wdctrl_ff[2:0]];

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      wdt_cnt_ff <= 15'h0;
    else if (FULL_RESET_O || key_bad || CLEAR_WDT_I || (HALT_I && !halted))
      wdt_cnt_ff <= 15'h0;
    else if (!wdt_enable)
      wdt_cnt_ff <= 15'h0;
    else if (overflow)
      wdt_cnt_ff <= 15'h0;
    else if (low_speed_rc_osc_tick)
      wdt_cnt_ff <= cnt_inc;
  end

  // halt mode control
  assign halted = (mode_ff != WDP_RUN);
  assign porta_wake = |(porta_d_ff & ~PORTA_I & porta_wake_mask_ff);
  assign irq_wake = |(IRQ_REQ_I & ~irq_mask_ff);
  assign wake = halted && (porta_wake || irq_wake || overflow);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      porta_d_ff <= 8'hff;
      irq_mask_ff <= 8'h00;
    end
    else
    begin
      porta_d_ff <= PORTA_I;
      if (HALT_I && !halted)
        irq_mask_ff <= IRQ_REQ_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      mode_ff <= WDP_RUN;
    else if (FULL_RESET_O || wake)
      mode_ff <= WDP_RUN;
    else if (HALT_I && !halted)
    begin
      case ({fast_osc_halt_keep_ff, slow_osc_halt_keep_ff})
        2'b01: mode_ff <= WDP_IDLE_SUB;
        2'b11: mode_ff <= WDP_IDLE_BOTH;
        2'b10: mode_ff <= WDP_IDLE_FAST;
        default: mode_ff <= WDP_SLEEP;
      endcase
    end
  end

  // clocks and stall; memory and ports untouched while halted
  assign CPU_STALL_O = halted;
  assign HS_CLK_EN_O = (mode_ff == WDP_RUN) || (mode_ff == WDP_IDLE_BOTH) ||
    (mode_ff == WDP_IDLE_FAST);
  assign SUB_CLK_EN_O = (mode_ff == WDP_RUN) || (mode_ff == WDP_IDLE_BOTH) ||
    (mode_ff == WDP_IDLE_SUB);
  assign SYS_CLK_EN_O = !halted;

  // wake outcome pulses
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      WAKE_RESUME_O <= 1'b0;
      WAKE_IRQ_O <= 1'b0;
      PC_SP_RESET_O <= 1'b0;
    end
    else
    begin
      PC_SP_RESET_O <= wake && overflow;
      WAKE_RESUME_O <= wake && !overflow && (porta_wake ||
        !(|(IRQ_REQ_I & ~irq_mask_ff & IRQ_EN_I)) || STACK_FULL_I);
      WAKE_IRQ_O <= wake && !overflow && !porta_wake &&
        (|(IRQ_REQ_I & ~irq_mask_ff & IRQ_EN_I)) && !STACK_FULL_I;
    end
  end

  // status flags; halt setting wins over a same-cycle clear instruction
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      powerdown_flag_ff <= 1'b0;
    else if (HALT_I && !halted)
      powerdown_flag_ff <= 1'b1;
    else if (CLEAR_WDT_I)
      powerdown_flag_ff <= 1'b0;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      watchdog_expired_flag_ff <= 1'b0;
    else if (overflow)
      watchdog_expired_flag_ff <= 1'b1;
    else if (HALT_I && !halted)
      watchdog_expired_flag_ff <= 1'b0;
  end

  assign POWERDOWN_FLAG_O = powerdown_flag_ff;
  assign WATCHDOG_EXPIRED_FLAG_O = watchdog_expired_flag_ff;

  // software duty: clear within the selected period
endmodule
`default_nettype wire

/* wdp_watchdog_assertions.sv */
// concurrent checks on the watchdog and power-down block ports
`timescale 1ns/1ns
`default_nettype none
module wdp_watchdog_chk (
  input wire logic CLK_SYS_I, // clock
  input wire logic RESET_N_I, // reset, active low
  input wire logic HALT_I, // halt pulse
  input wire logic CLEAR_WDT_I, // clear pulse
  input wire logic STACK_FULL_I, // stack full
  input wire logic CPU_STALL_O, // stalled
  input wire logic HS_CLK_EN_O, // fast clock on
  input wire logic SUB_CLK_EN_O, // sub clock on
  input wire logic SYS_CLK_EN_O, // system clock on
  input wire logic WAKE_RESUME_O, // resume pulse
  input wire logic WAKE_IRQ_O, // interrupt pulse
  input wire logic PC_SP_RESET_O, // pc and sp reset
  input wire logic FULL_RESET_O, // full reset
  input wire logic POWERDOWN_FLAG_O, // powerdown flag
  input wire logic WATCHDOG_EXPIRED_FLAG_O // expired flag
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  a_halt_sets_flags: assert property (HALT_I && !CPU_STALL_O |=> POWERDOWN_FLAG_O && !WATCHDOG_EXPIRED_FLAG_O)
    else $error("flags wrong after halt");
  a_halt_stalls_cpu: assert property (HALT_I && !CPU_STALL_O |=> CPU_STALL_O)
    else $error("no stall after halt");
  a_sleep_sysclk_off: assert property (CPU_STALL_O && !HS_CLK_EN_O && !SUB_CLK_EN_O |-> !SYS_CLK_EN_O)
    else $error("system clock runs in sleep");
  a_wake_ends_stall: assert property (WAKE_RESUME_O || WAKE_IRQ_O |-> !CPU_STALL_O && $past(CPU_STALL_O))
    else $error("wake pulse without halt");
  a_irq_needs_room: assert property (WAKE_IRQ_O |-> !$past(STACK_FULL_I))
    else $error("interrupt taken with stack full");
  a_resume_one_cycle: assert property (WAKE_RESUME_O |=> !WAKE_RESUME_O)
    else $error("resume pulse too long");
  a_pdf_holds_set: assert property (POWERDOWN_FLAG_O && !CLEAR_WDT_I |=> POWERDOWN_FLAG_O)
    else $error("powerdown flag lost");
  a_full_reset_len: assert property ($rose(FULL_RESET_O) |=>
    FULL_RESET_O [*8] ##1 FULL_RESET_O [*7] ##1 !FULL_RESET_O)
    else $error("full reset length wrong");
  c_resume: cover property (WAKE_RESUME_O);
  c_irq: cover property (WAKE_IRQ_O);
  c_reset: cover property ($rose(FULL_RESET_O));
endmodule
bind wdp_watchdog wdp_watchdog_chk chk (.*);
`default_nettype wire

/* wdp_watchdog_tb.sv */
// testbench for the watchdog and power-down block
`timescale 1ns/1ns
`default_nettype none
module wdp_watchdog_tb;
  import wdp_pkg::*;
  logic CLK_SYS_I, RESET_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic HALT_I, CLEAR_WDT_I, STACK_FULL_I, halt_req, clr_req;
  logic [7:0] AWADDR_I, ARADDR_I, PORTA_I, IRQ_REQ_I, IRQ_EN_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [3:0] WSTRB_I;
  logic [1:0] BRESP_O, RRESP_O, rr, rb;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CPU_STALL_O, HS_CLK_EN_O;
  logic SUB_CLK_EN_O, SYS_CLK_EN_O, WAKE_RESUME_O, WAKE_IRQ_O, PC_SP_RESET_O, FULL_RESET_O;
  logic POWERDOWN_FLAG_O, WATCHDOG_EXPIRED_FLAG_O;
  int miscompares = 0;
  int check_count = 0;
  wdp_mode_e md [4] = '{WDP_SLEEP, WDP_IDLE_SUB, WDP_IDLE_FAST, WDP_IDLE_BOTH};
  wdp_watchdog uut (.*);
  wdp_cpu_model cpu (.clk_i(CLK_SYS_I), .rst_n_i(RESET_N_I), .stall_i(CPU_STALL_O),
    .halt_req_i(halt_req), .clr_req_i(clr_req), .halt_o(HALT_I), .clear_o(CLEAR_WDT_I));
  task test_done;
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 60)
    begin
      chk(32'h0, 32'h1);
      test_done;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge CLK_SYS_I);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
      if (BVALID_O) break;
    end
    rb = BRESP_O;
    BREADY_I <= 1'b0;
    tmo(n);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge CLK_SYS_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge CLK_SYS_I);
      if (ARREADY_O) ARVALID_I <= 1'b0;
      if (RVALID_O) break;
    end
    rr = RRESP_O;
    RREADY_I <= 1'b0;
    tmo(n);
    chk(RDATA_O, e);
  endtask
  task halt;
    @(posedge CLK_SYS_I);
    halt_req <= 1'b1;
    @(posedge CLK_SYS_I);
    halt_req <= 1'b0;
    repeat (3) @(posedge CLK_SYS_I);
  endtask
  task wake(input logic irq);
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(posedge CLK_SYS_I);
      if (WAKE_RESUME_O || WAKE_IRQ_O) break;
    end
    tmo(n);
    chk(WAKE_IRQ_O, irq);
    chk(WAKE_RESUME_O, !irq);
    chk(PC_SP_RESET_O, 1'b0);
    chk(CPU_STALL_O, 1'b0);
  endtask
  initial
  begin
    CLK_SYS_I = 1'b0;
    forever #4 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial
  begin
    repeat (100000) @(posedge CLK_SYS_I);
    chk(32'h0, 32'h1);
    test_done;
  end
  initial
  begin
    int n;
    RESET_N_I = 1'b0;
    {AWADDR_I, ARADDR_I, IRQ_REQ_I, IRQ_EN_I, WDATA_I} = '0;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, STACK_FULL_I, halt_req, clr_req} = '0;
    WSTRB_I = 4'hf;
    PORTA_I = 8'hff;
    repeat (4) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    rchk(8'h00, 32'h53);
    rchk(8'h04, 32'h0);
    rchk(8'h14, 32'h0);
    chk(rr, 2'b10);
    wr(8'h14, 32'h0);
    chk(rb, 2'b10);
    wr(8'h10, 32'h1);
    chk(rb, 2'b00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h08, i);
      halt;
      chk(CPU_STALL_O, 1'b1);
      chk({HS_CLK_EN_O, SUB_CLK_EN_O}, i[1:0]);
      chk(SYS_CLK_EN_O, 1'b0);
      chk(POWERDOWN_FLAG_O, 1'b1);
      chk(WATCHDOG_EXPIRED_FLAG_O, 1'b0);
      // status: expired at bit 5, powerdown at bit 4, bit 3 spare
      rchk(8'h0c, {27'h0, 1'b1, 1'b0, md[i]});
      PORTA_I <= 8'hfe;
      wake(1'b0);
      PORTA_I <= 8'hff;
    end
    clr_req <= 1'b1;
    repeat (3) @(posedge CLK_SYS_I);
    clr_req <= 1'b0;
    rchk(8'h0c, 32'h0);
    chk(POWERDOWN_FLAG_O, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      IRQ_EN_I <= {7'h0, i != 1};
      STACK_FULL_I <= (i == 2);
      halt;
      IRQ_REQ_I <= 8'h01;
      wake(i == 0);
      IRQ_REQ_I <= 8'h00;
    end
    // request already pending at halt must not wake
    IRQ_REQ_I <= 8'h01;
    halt;
    repeat (8) @(posedge CLK_SYS_I);
    chk(CPU_STALL_O, 1'b1);
    PORTA_I <= 8'hfe;
    wake(1'b0);
    PORTA_I <= 8'hff;
    IRQ_REQ_I <= 8'h00;
    wr(8'h00, 32'hab);
    rchk(8'h00, 32'hab);
    wr(8'h00, 32'h53);
    rchk(8'h00, 32'h53);
    wr(8'h00, 32'h03);
    for (n = 0; n < 20000 && !FULL_RESET_O; n++) @(posedge CLK_SYS_I);
    chk(FULL_RESET_O, 1'b1);
    chk(n > 12000 && n < 13000, 1'b1);
    repeat (20) @(posedge CLK_SYS_I);
    rchk(8'h04, 32'h1);
    rchk(8'h00, 32'h53);
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
